//--- verilog/pemoc_consts.vh
/*
  register map, field layout, reset value and monitor-rate timing
  for the protection enable and monitor output configuration block.
  assumes inclusion by bare name from design files under verilog/.
*/
`ifndef PEMOC_CONSTS_VH
`define PEMOC_CONSTS_VH

// ****************************************************************
// register map
// ****************************************************************
`define PEMOC_ADDR_W 4
`define PEMOC_DATA_W 16
`define PEMOC_CFG_ADDR 4'h0
`define PEMOC_STAT_ADDR 4'h1
`define PEMOC_CFG_RESET 16'h1800
// bits software may store; bit 7 is reserved
`define PEMOC_CFG_WMASK 16'hff7f

// ****************************************************************
// field positions
// ****************************************************************
`define PEMOC_IN1_OT 15
`define PEMOC_IN3_OT 14
`define PEMOC_IN5_OT 13
`define PEMOC_IN2_OC 12
`define PEMOC_IN4_OC 11
`define PEMOC_IN6_OC 10
`define PEMOC_FREQ_HI 9
`define PEMOC_FREQ_LO 8
`define PEMOC_SEL_HI 6
`define PEMOC_SEL_LO 0
`define PEMOC_SEL_N 7
// status: bit 0 selection valid, bit 1 selection conflict
`define PEMOC_ST_VALID 0
`define PEMOC_ST_CONFLICT 1

// ****************************************************************
// monitor output rates, in core clocks at 250 MHz (period 4 ns)
// ****************************************************************
`define PEMOC_CLK_HZ 250000000
`define PEMOC_RATE_W 15
// half periods: 250e6 / (2 * f), rounded down
`define PEMOC_HALF0 15'd8992
`define PEMOC_HALF1 15'd4496
`define PEMOC_HALF2 15'd2244
`define PEMOC_HALF3 15'd1122
`define PEMOC_FREQ_0 2'h0
`define PEMOC_FREQ_1 2'h1
`define PEMOC_FREQ_2 2'h2
`define PEMOC_FREQ_3 2'h3

`endif

//--- verilog/pemoc_rate_gen.v
/*
  monitor output rate generator: a square wave at the selected frequency
  code. assumes core_clk at 250 MHz and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pemoc_consts.vh"

module pemoc_rate_gen (
  input wire core_clk, // core clock
  input wire reset_n, // async reset, active low
  input wire run, // count while high, else hold low
  input wire [1:0] freqCode, // frequency select code
  output reg rateOut // square wave
);

  reg [`PEMOC_RATE_W-1:0] count;
  reg [`PEMOC_RATE_W-1:0] halfLimit;

  // ****************************************************************
  // half period per code
  // ****************************************************************
  always @* begin
    case (freqCode)
      `PEMOC_FREQ_0: halfLimit = `PEMOC_HALF0;
      `PEMOC_FREQ_1: halfLimit = `PEMOC_HALF1;
      `PEMOC_FREQ_2: halfLimit = `PEMOC_HALF2;
      default: halfLimit = `PEMOC_HALF3;
    endcase
  end

  // ****************************************************************
  // toggle counter
  // ****************************************************************
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= {`PEMOC_RATE_W{1'b0}};
      rateOut <= 1'b0;
    end else if (!run) begin
      count <= {`PEMOC_RATE_W{1'b0}};
      rateOut <= 1'b0;
    end else if (count >= halfLimit - 1'b1) begin
      count <= {`PEMOC_RATE_W{1'b0}};
      rateOut <= ~rateOut;
    end else begin
      count <= count + 1'b1;
    end
  end

endmodule
`default_nettype wire

//--- verilog/pemoc_config.v
/*
  protection enable and monitor output configuration register with its
  decoded outputs and monitor output gating.
  assumes a simple register port on core_clk: one-cycle strobes, read data
  valid the cycle after the read strobe; measurement bits arrive from
  logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pemoc_consts.vh"

module pemoc_config (
  input wire core_clk, // core clock, 250 MHz
  input wire reset_n, // async reset, active low
  input wire [`PEMOC_ADDR_W-1:0] regAddr, // register address
  input wire [`PEMOC_DATA_W-1:0] regWrData, // write data
  input wire regWrite, // write strobe
  input wire regRead, // read strobe
  output reg [`PEMOC_DATA_W-1:0] regRdData, // read data, cycle after strobe
  output wire input1OvertempEnable, // overtemp enable, input 1
  output wire input3OvertempEnable, // overtemp enable, input 3
  output wire input5OvertempEnable, // overtemp enable, input 5
  output wire input2OvercurrentEnable, // overcurrent enable, input 2
  output wire input4OvercurrentEnable, // overcurrent enable, input 4
  output wire input6OvercurrentEnable, // overcurrent enable, input 6
  output wire [1:0] monitorOutFrequency, // rate code
  output wire [`PEMOC_SEL_N-1:0] monitorSel, // one-hot source select
  input wire [`PEMOC_SEL_N-1:0] sourceBit, // measurement bit per source
  output reg monitorOut // monitor output data
);

  reg [`PEMOC_DATA_W-1:0] cfg;
  wire [`PEMOC_SEL_N-1:0] sel;
  wire [`PEMOC_SEL_N-1:0] lowerSel;
  wire selConflict;
  wire selValid;
  wire rateOut;
  wire sourceData;

  // ****************************************************************
  // configuration register
  // ****************************************************************
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= `PEMOC_CFG_RESET;
    end else if (regWrite && regAddr == `PEMOC_CFG_ADDR) begin
      cfg <= regWrData & `PEMOC_CFG_WMASK;
    end
  end

  // protection enables straight from the register
  assign input1OvertempEnable = cfg[`PEMOC_IN1_OT];
  assign input3OvertempEnable = cfg[`PEMOC_IN3_OT];
  assign input5OvertempEnable = cfg[`PEMOC_IN5_OT];
  assign input2OvercurrentEnable = cfg[`PEMOC_IN2_OC];
  assign input4OvercurrentEnable = cfg[`PEMOC_IN4_OC];
  assign input6OvercurrentEnable = cfg[`PEMOC_IN6_OC];
  assign monitorOutFrequency = cfg[`PEMOC_FREQ_HI:`PEMOC_FREQ_LO];
  assign sel = cfg[`PEMOC_SEL_HI:`PEMOC_SEL_LO];

  // ****************************************************************
  // select check: any bit set while a lower one is also set
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < `PEMOC_SEL_N; i = i + 1) begin : gLower
      if (i == 0) begin : gFirst
        assign lowerSel[i] = 1'b0;
      end else begin : gRest
        assign lowerSel[i] = lowerSel[i-1] | sel[i-1];
      end
    end
  endgenerate

  assign selConflict = |(sel & lowerSel);
  assign selValid = (|sel) & ~selConflict;
  assign monitorSel = selValid ? sel : {`PEMOC_SEL_N{1'b0}};
  assign sourceData = |(monitorSel & sourceBit);

  // ****************************************************************
  // rate generator paces the monitor output
  // ****************************************************************
  pemoc_rate_gen uRate (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .run(selValid),
    .freqCode(monitorOutFrequency),
    .rateOut(rateOut)
  );

  // output data: selected source gated by the rate wave
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      monitorOut <= 1'b0;
    end else begin
      monitorOut <= selValid & rateOut & sourceData;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= {`PEMOC_DATA_W{1'b0}};
    end else if (regRead && regAddr == `PEMOC_CFG_ADDR) begin
      regRdData <= cfg;
    end else if (regRead && regAddr == `PEMOC_STAT_ADDR) begin
      regRdData <= {{(`PEMOC_DATA_W-2){1'b0}}, selConflict, selValid};
    end else begin
      regRdData <= {`PEMOC_DATA_W{1'b0}};
    end
  end

endmodule
`default_nettype wire

//--- dv/pemoc_config_monitor.sv
/* checker for the configuration register outputs and monitor gating.
   assumes binding onto pemoc_config, one clock core_clk, reset reset_n. */
`timescale 1ns/1ps
`default_nettype none
module pemoc_config_monitor (
  input wire logic core_clk, // core clock
  input wire logic reset_n, // async reset, active low
  input wire logic [3:0] regAddr, // register address
  input wire logic [15:0] regWrData, // write data
  input wire logic regWrite, // write strobe
  input wire logic regRead, // read strobe
  input wire logic [15:0] regRdData, // read data
  input wire logic input1OvertempEnable, // bit 15
  input wire logic input2OvercurrentEnable, // bit 12
  input wire logic input6OvercurrentEnable, // bit 10
  input wire logic [1:0] monitorOutFrequency, // bits 9..8
  input wire logic [6:0] monitorSel, // source select
  input wire logic monitorOut // monitor data
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // config write taken this edge
  sequence cfgWr; regWrite && regAddr == 4'h0; endsequence
  a_ot_enable_write: assert property (cfgWr |=> input1OvertempEnable == $past(regWrData[15]))
    else $error("overtemp enable wrong");
  a_oc_enable_write: assert property (cfgWr |=> input2OvercurrentEnable == $past(regWrData[12]))
    else $error("overcurrent enable wrong");
  a_oc6_enable_write: assert property (cfgWr |=> input6OvercurrentEnable == $past(regWrData[10]))
    else $error("input 6 enable wrong");
  a_freq_field_write: assert property (cfgWr |=> monitorOutFrequency == $past(regWrData[9:8]))
    else $error("rate code wrong");
  a_die_temp_sel: assert property (cfgWr and regWrData[6:0] == 7'h40 |=> monitorSel == 7'h40)
    else $error("die temp select wrong");
  a_input_sel_follows: assert property (cfgWr and !regWrData[6] and $onehot(regWrData[5:0])
    |=> monitorSel == $past(regWrData[6:0]))
    else $error("input select wrong");
  a_conflict_silences: assert property (cfgWr and $countones(regWrData[6:0]) > 1
    |=> monitorSel == 7'h0 ##1 !monitorOut)
    else $error("conflict not silenced");
  a_reserved_reads_zero: assert property (regRead && regAddr == 4'h0 |=> !regRdData[7])
    else $error("reserved bit set");
endmodule
bind pemoc_config pemoc_config_monitor u_mon (.core_clk(core_clk), .reset_n(reset_n),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .input1OvertempEnable(input1OvertempEnable),
  .input2OvercurrentEnable(input2OvercurrentEnable),
  .input6OvercurrentEnable(input6OvercurrentEnable),
  .monitorOutFrequency(monitorOutFrequency), .monitorSel(monitorSel), .monitorOut(monitorOut));
`default_nettype wire

//--- dv/pemoc_config_tb.sv
/* self-checking bench for the configuration register block.
   assumes pemoc_config with a 4 ns core clock. */
`timescale 1ns/1ps
`default_nettype none
module pemoc_config_tb;
  logic core_clk = 0, reset_n = 0, regWrite = 0, regRead = 0, monitorOut;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0, regRdData, q, e;
  logic [5:0] en;
  logic [1:0] monitorOutFrequency;
  logic [6:0] monitorSel, sourceBit = 7'h7f;
  int bad_count = 0, n_tests = 0, cyc = 0, hit;
  logic [15:0] rows [11] = '{16'hffff, 16'h8001, 16'h4102, 16'h2204, 16'h1308, 16'h0c10,
    16'h0020, 16'h0040, 16'h0000, 16'h0003, 16'h0380};
  pemoc_config u_dut (.core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .input1OvertempEnable(en[5]), .input3OvertempEnable(en[4]), .input5OvertempEnable(en[3]),
    .input2OvercurrentEnable(en[2]), .input4OvercurrentEnable(en[1]),
    .input6OvercurrentEnable(en[0]), .monitorOutFrequency(monitorOutFrequency),
    .monitorSel(monitorSel), .sourceBit(sourceBit), .monitorOut(monitorOut));
  // clock and hang guard
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 12000) begin
      bad_count++;
      close_out();
    end
  end
  task close_out();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(string n, logic [15:0] x, logic [15:0] g);
    n_tests++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  // one-cycle bus strobes, driven just after an edge
  task wr(logic [3:0] a, logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1;
    @(posedge core_clk);
    regWrite <= 0;
  endtask
  task rd(logic [3:0] a);
    regAddr <= a;
    regRead <= 1;
    @(posedge core_clk);
    regRead <= 0;
    #1 q = regRdData;
  endtask
  // full check of register and decoded outputs
  task chk_all(logic [15:0] d);
    rd(4'h0);
    chk("readback", d & 16'hff7f, q);
    chk("enables", 16'(d[15:10]), 16'(en));
    chk("rate", 16'(d[9:8]), 16'(monitorOutFrequency));
    chk("select", ($countones(d[6:0]) == 1) ? 16'(d[6:0]) : 16'h0, 16'(monitorSel));
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1;
    @(posedge core_clk);
    chk_all(16'h1800);
    $display("reset values done");
    foreach (rows[i]) begin
      wr(4'h0, rows[i]);
      chk_all(rows[i]);
    end
    $display("row table done");
    // unmapped write, one idle cycle, then config write and unmapped read zero back to back
    wr(4'h5, 16'h0000);
    @(posedge core_clk);
    wr(4'h0, 16'h0301);
    rd(4'h5);
    chk("unmapped", 16'h0, q);
    chk_all(16'h0301);
    rd(4'h1);
    chk("status valid", 16'h0001, q);
    $display("unmapped access done");
    // fastest rate, input 1 selected: output must toggle on
    hit = 0;
    repeat (2300) @(posedge core_clk) if (monitorOut === 1'b1) hit = 1;
    chk("wave seen", 16'h1, 16'(hit));
    // selected source low: output must stay low
    sourceBit <= 7'h7e;
    repeat (2) @(posedge core_clk);
    hit = 0;
    repeat (2300) @(posedge core_clk) if (monitorOut !== 1'b0) hit = 1;
    chk("source low quiet", 16'h0, 16'(hit));
    sourceBit <= 7'h7f;
    wr(4'h0, 16'h0303);
    repeat (2) @(posedge core_clk);
    hit = 0;
    repeat (2300) @(posedge core_clk) if (monitorOut !== 1'b0) hit = 1;
    chk("conflict quiet", 16'h0, 16'(hit));
    rd(4'h1);
    chk("status conflict", 16'h0002, q);
    $display("monitor output done");
    close_out();
  end
endmodule
`default_nettype wire
